// ---- src/pav_regs_top.sv ----
// Picture adjust and blanking-data request register bank with its luma and chroma adjust path.
// Assumes a serial control front end that turns bus transfers into sub-address strobes on the
// same clock, and a blanking-data slicer on the same clock that pulses done with its decoded word.
//
// Operation
// - Contrast is unsigned luma gain value/128, unity at reset value 0x80.
// - Brightness is a signed two's complement offset added to luma.
// - Brightness resets to 0x00, giving no offset.
// - Saturation scales both chroma components by value/128, maximum 255/128.
// - Saturation zero gives zero chroma, no colour.
// - Saturation resets to 0x80, unity chroma gain.
// - Hue is signed phase rotation, about 0.35 degrees a step, within 45 degrees.
// - Hue resets to 0x00, no rotation.
// - Request register is write-only; bits 0,1,2 request caption, extended, vbid/wss.
// - Writing a request one arms that decoder to wait for blanking data.
// - Any request one clears all three present flags at once, bar the flag of an armed decode finishing that same cycle.
// - Finished decode of an armed type sets its present flag at 0x10.
// - Decoded words are stored in caption, extended and vbid/wss register pairs.
// - Y/C delay unit is one output sample clock period.
// - Delay code 000 aligns Y and C; 101 delays Y three cycles.
// - Codes 110 and 111 delay Y one cycle behind C.
// - Codes 001 and 010 advance Y two cycles ahead of C.
// - Caption, extended, vbid/wss present flags sit at status bits 5, 6, 7.
`timescale 1ns/10ps
`default_nettype none
`include "pav_regs.svh"

module pav_regs_top (
	// Clock and reset.
	input  wire logic                clock,
	input  wire logic                reset_n,
	// Register port from the serial control front end.
	input  wire logic [7:0]          reg_address,
	input  wire logic                reg_write_strobe,
	input  wire logic [7:0]          reg_write_data,
	output var  logic [7:0]          reg_read_data,
	// Sample stream in, one sample per clock.
	input  wire logic                sample_valid,
	input  wire logic [7:0]          luma_in,
	input  wire logic signed [7:0]   cb_in,
	input  wire logic signed [7:0]   cr_in,
	// Sample stream out.
	output var  logic                sample_valid_out,
	output var  logic [7:0]          luma_out,
	output var  logic signed [7:0]   cb_out,
	output var  logic signed [7:0]   cr_out,
	// Blanking-data slicer.
	input  wire logic [2:0]          decode_done,
	input  wire logic [15:0]         caption_word,
	input  wire logic [15:0]         extended_word,
	input  wire logic [15:0]         vbid_wss_word,
	input  wire logic [4:0]          engine_status,
	output var  logic [2:0]          decode_ready
);

	//--------------------------------------------------------------------
	// Control registers
	//--------------------------------------------------------------------
	pav_pkg::pav_byte_type contrast_gain_q, contrast_gain_d;
	pav_pkg::pav_byte_type brightness_offset_q, brightness_offset_d;
	pav_pkg::pav_byte_type saturation_gain_q, saturation_gain_d;
	pav_pkg::pav_byte_type hue_rotation_q, hue_rotation_d;
	logic [2:0]            luma_chroma_delay_q, luma_chroma_delay_d;
	logic                  request_hit;
	logic [2:0]            request_bits;

	// Request bits are decoded straight off the write and never stored.
	assign request_hit  = reg_write_strobe && (reg_address == `PAV_ADDR_DECODE_REQ);
	assign request_bits = request_hit ? reg_write_data[2:0] : 3'h0;

	always_comb begin
		contrast_gain_d     = contrast_gain_q;
		brightness_offset_d = brightness_offset_q;
		saturation_gain_d   = saturation_gain_q;
		hue_rotation_d      = hue_rotation_q;
		luma_chroma_delay_d = luma_chroma_delay_q;
		if (reg_write_strobe) begin
			case (reg_address)
				`PAV_ADDR_CONTRAST:   contrast_gain_d     = reg_write_data;
				`PAV_ADDR_BRIGHTNESS: brightness_offset_d = reg_write_data;
				`PAV_ADDR_SATURATION: saturation_gain_d   = reg_write_data;
				`PAV_ADDR_HUE:        hue_rotation_d      = reg_write_data;
				`PAV_ADDR_YC_DELAY:   luma_chroma_delay_d = reg_write_data[2:0];
				default:              ;
			endcase
		end
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			contrast_gain_q     <= `PAV_RESET_CONTRAST;
			brightness_offset_q <= `PAV_RESET_BRIGHTNESS;
			saturation_gain_q   <= `PAV_RESET_SATURATION;
			hue_rotation_q      <= `PAV_RESET_HUE;
			luma_chroma_delay_q <= `PAV_RESET_YC_DELAY;
		end else begin
			contrast_gain_q     <= contrast_gain_d;
			brightness_offset_q <= brightness_offset_d;
			saturation_gain_q   <= saturation_gain_d;
			hue_rotation_q      <= hue_rotation_d;
			luma_chroma_delay_q <= luma_chroma_delay_d;
		end
	end

	//--------------------------------------------------------------------
	// Blanking-data decode channels
	//--------------------------------------------------------------------
	logic [15:0] word_in [3];
	logic [15:0] word_q [3];
	logic [2:0]  present_flag;

	assign word_in[0] = caption_word;
	assign word_in[1] = extended_word;
	assign word_in[2] = vbid_wss_word;

	for (genvar i = 0; i < 3; i++) begin : g_channel
		pav_pkg::pav_decode_state_type state_q, state_d;
		logic                          flag_q, flag_d;
		pav_pkg::pav_word_type         data_q, data_d;

		// The set from a finished decode is applied after the clear, so it wins.
		always_comb begin
			state_d = state_q;
			flag_d  = flag_q;
			data_d  = data_q;
			if (|request_bits) begin
				flag_d = 1'b0;
			end
			if (state_q == pav_pkg::PAV_ARMED && decode_done[i]) begin
				flag_d  = 1'b1;
				data_d  = word_in[i];
				state_d = pav_pkg::PAV_IDLE;
			end
			if (request_bits[i]) begin
				state_d = pav_pkg::PAV_ARMED;
			end
		end

		always_ff @(posedge clock or negedge reset_n) begin
			if (!reset_n) begin
				state_q <= pav_pkg::PAV_IDLE;
				flag_q  <= 1'b0;
				data_q  <= 16'h0000;
			end else begin
				state_q <= state_d;
				flag_q  <= flag_d;
				data_q  <= data_d;
			end
		end

		assign present_flag[i] = flag_q;
		assign decode_ready[i] = (state_q == pav_pkg::PAV_ARMED);
		assign word_q[i]       = data_q;
	end

	//--------------------------------------------------------------------
	// Register readback
	//--------------------------------------------------------------------
	pav_pkg::pav_byte_type read_d;

	always_comb begin
		case (reg_address)
			`PAV_ADDR_CONTRAST:    read_d = contrast_gain_q;
			`PAV_ADDR_BRIGHTNESS:  read_d = brightness_offset_q;
			`PAV_ADDR_SATURATION:  read_d = saturation_gain_q;
			`PAV_ADDR_HUE:         read_d = hue_rotation_q;
			`PAV_ADDR_YC_DELAY:    read_d = {5'h00, luma_chroma_delay_q};
			`PAV_ADDR_STATUS:      read_d = {present_flag, engine_status};
			`PAV_ADDR_CAPTION_LO:  read_d = word_q[0][7:0];
			`PAV_ADDR_CAPTION_HI:  read_d = word_q[0][15:8];
			`PAV_ADDR_EXTENDED_LO: read_d = word_q[1][7:0];
			`PAV_ADDR_EXTENDED_HI: read_d = word_q[1][15:8];
			`PAV_ADDR_VBID_WSS_LO: read_d = word_q[2][7:0];
			`PAV_ADDR_VBID_WSS_HI: read_d = word_q[2][15:8];
			default:               read_d = 8'h00;
		endcase
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			reg_read_data <= 8'h00;
		end else begin
			reg_read_data <= read_d;
		end
	end

	//--------------------------------------------------------------------
	// Gain, offset and hue path
	//--------------------------------------------------------------------
	function automatic logic [7:0] clamp_unsigned(input logic signed [11:0] value);
		if (value < 0)
			return 8'h00;
		else if (value > 12'sd255)
			return 8'hff;
		else
			return value[7:0];
	endfunction : clamp_unsigned

	function automatic logic signed [7:0] clamp_signed(input logic signed [15:0] value);
		if (value < -16'sd128)
			return 8'h80;
		else if (value > 16'sd127)
			return 8'h7f;
		else
			return value[7:0];
	endfunction : clamp_signed

	logic [7:0]        luma_s1_q, luma_s1_d, luma_s2_q;
	logic signed [7:0] cb_s1_q, cb_s1_d, cr_s1_q, cr_s1_d;
	logic signed [7:0] cb_s2_q, cb_s2_d, cr_s2_q, cr_s2_d;
	logic [1:0]        valid_s_q;
	logic [15:0]       luma_prod;
	logic signed [11:0] luma_sum;
	logic signed [16:0] cb_prod, cr_prod;
	logic signed [20:0] cb_turn, cr_turn;

	always_comb begin
		luma_prod = luma_in * contrast_gain_q;
		luma_sum  = $signed({3'h0, luma_prod[15:7]}) + 12'($signed(brightness_offset_q));
		luma_s1_d = clamp_unsigned(luma_sum);
		cb_prod   = cb_in * $signed({1'b0, saturation_gain_q});
		cr_prod   = cr_in * $signed({1'b0, saturation_gain_q});
		cb_s1_d   = clamp_signed(16'(cb_prod >>> `PAV_GAIN_SHIFT));
		cr_s1_d   = clamp_signed(16'(cr_prod >>> `PAV_GAIN_SHIFT));
		// Small-angle rotation: 25/4096 rad a step is about 0.35 degrees; cosine is taken as one.
		cb_turn   = cr_s1_q * $signed(hue_rotation_q) * $signed({1'b0, `PAV_HUE_MULT});
		cr_turn   = cb_s1_q * $signed(hue_rotation_q) * $signed({1'b0, `PAV_HUE_MULT});
		cb_s2_d   = clamp_signed(16'(cb_s1_q) - 16'(cb_turn >>> `PAV_HUE_SHIFT));
		cr_s2_d   = clamp_signed(16'(cr_s1_q) + 16'(cr_turn >>> `PAV_HUE_SHIFT));
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			luma_s1_q <= 8'h00;
			luma_s2_q <= 8'h00;
			cb_s1_q   <= 8'h00;
			cr_s1_q   <= 8'h00;
			cb_s2_q   <= 8'h00;
			cr_s2_q   <= 8'h00;
			valid_s_q <= 2'h0;
		end else begin
			luma_s1_q <= luma_s1_d;
			luma_s2_q <= luma_s1_q;
			cb_s1_q   <= cb_s1_d;
			cr_s1_q   <= cr_s1_d;
			cb_s2_q   <= cb_s2_d;
			cr_s2_q   <= cr_s2_d;
			valid_s_q <= {valid_s_q[0], sample_valid};
		end
	end

	//--------------------------------------------------------------------
	// Y/C relative delay
	//--------------------------------------------------------------------
	logic [7:0]        luma_line_q [1:3];
	logic signed [7:0] cb_line_q [1:2];
	logic signed [7:0] cr_line_q [1:2];
	logic [2:0]        valid_line_q;
	logic [1:0]        luma_tap, chroma_tap;
	logic [7:0]        luma_out_d;
	logic signed [7:0] cb_out_d, cr_out_d;
	logic              valid_out_d;

	always_comb begin
		case (luma_chroma_delay_q)
			`PAV_YC_DELAY_Y3: begin
				luma_tap = 2'd3;
				chroma_tap = 2'd0;
			end
			`PAV_YC_DELAY_Y1A, `PAV_YC_DELAY_Y1B: begin
				luma_tap = 2'd1;
				chroma_tap = 2'd0;
			end
			`PAV_YC_ADV_C2A, `PAV_YC_ADV_C2B: begin
				luma_tap = 2'd0;
				chroma_tap = 2'd2;
			end
			default: begin
				luma_tap = 2'd0;
				chroma_tap = 2'd0;
			end
		endcase
		luma_out_d  = (luma_tap == 2'd0) ? luma_s2_q : luma_line_q[luma_tap];
		cb_out_d    = (chroma_tap == 2'd0) ? cb_s2_q : cb_line_q[2];
		cr_out_d    = (chroma_tap == 2'd0) ? cr_s2_q : cr_line_q[2];
		valid_out_d = (luma_tap == 2'd0 && chroma_tap == 2'd0) ? valid_s_q[1] :
			valid_line_q[(luma_tap > chroma_tap) ? luma_tap - 2'd1 : chroma_tap - 2'd1];
	end

	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			luma_line_q      <= '{default: 8'h00};
			cb_line_q        <= '{default: 8'h00};
			cr_line_q        <= '{default: 8'h00};
			valid_line_q     <= 3'h0;
			luma_out         <= 8'h00;
			cb_out           <= 8'h00;
			cr_out           <= 8'h00;
			sample_valid_out <= 1'b0;
		end else begin
			luma_line_q      <= '{luma_s2_q, luma_line_q[1], luma_line_q[2]};
			cb_line_q        <= '{cb_s2_q, cb_line_q[1]};
			cr_line_q        <= '{cr_s2_q, cr_line_q[1]};
			valid_line_q     <= {valid_line_q[1:0], valid_s_q[1]};
			luma_out         <= luma_out_d;
			cb_out           <= cb_out_d;
			cr_out           <= cr_out_d;
			sample_valid_out <= valid_out_d;
		end
	end

	//--------------------------------------------------------------------
	// Assertions
	//--------------------------------------------------------------------
	default clocking cb_main @(posedge clock); endclocking
	default disable iff (!reset_n);

	sequence s_request_write;
		request_hit && (reg_write_data[2:0] != 3'h0) && (decode_done == 3'h0);
	endsequence

	sequence s_delay_y3_held;
		(luma_chroma_delay_q == `PAV_YC_DELAY_Y3) [*5];
	endsequence

	a_unity_contrast: assert property (
		contrast_gain_q == 8'h80 && brightness_offset_q == 8'h00 ##1 $stable(contrast_gain_q) |->
		luma_s1_q == $past(luma_in)) else $error("unity contrast altered luma");
	a_bright_offset: assert property (
		contrast_gain_q == 8'h80 && !brightness_offset_q[7] && luma_in < 8'h40 |=>
		luma_s1_q == $past(luma_in) + $past(brightness_offset_q)) else $error("brightness offset wrong");
	a_zero_saturation: assert property (
		saturation_gain_q == 8'h00 |=> cb_s1_q == 8'h00 && cr_s1_q == 8'h00) else $error("chroma not killed");
	a_unity_saturation: assert property (
		saturation_gain_q == 8'h80 |=> cb_s1_q == $past(cb_in) && cr_s1_q == $past(cr_in))
		else $error("unity saturation altered chroma");
	a_hue_zero: assert property (
		hue_rotation_q == 8'h00 |=> cb_s2_q == $past(cb_s1_q) && cr_s2_q == $past(cr_s1_q))
		else $error("zero hue rotated chroma");
	a_request_clears: assert property (
		s_request_write |=> present_flag == 3'h0) else $error("request did not clear flags");
	a_done_sets: assert property (
		decode_ready[0] && decode_done[0] && !request_bits[0] |=>
		present_flag[0] && !decode_ready[0] ##0 word_q[0] == $past(caption_word))
		else $error("caption done not recorded");
	a_flag_holds: assert property (
		present_flag[1] && request_bits == 3'h0 |=> present_flag[1]) else $error("flag dropped without request");
	a_delay_three: assert property (
		s_delay_y3_held |=> luma_out == $past(luma_s2_q, 4) && cb_out == $past(cb_s2_q))
		else $error("luma not delayed three cycles");

endmodule : pav_regs_top

`default_nettype wire

// ---- src/pav_regs.svh ----
// Offsets, field positions, reset values and arithmetic constants of the picture adjust register bank.
// Assumes an 8-bit sub-address space; included by the bank module only, not by the package.
`ifndef PAV_REGS_SVH
`define PAV_REGS_SVH

`define PAV_ADDR_CONTRAST      8'h06
`define PAV_ADDR_BRIGHTNESS    8'h07
`define PAV_ADDR_SATURATION    8'h08
`define PAV_ADDR_HUE           8'h09
`define PAV_ADDR_DECODE_REQ    8'h0a
`define PAV_ADDR_YC_DELAY      8'h0b
`define PAV_ADDR_STATUS        8'h10
`define PAV_ADDR_CAPTION_LO    8'h12
`define PAV_ADDR_CAPTION_HI    8'h13
`define PAV_ADDR_EXTENDED_LO   8'h14
`define PAV_ADDR_EXTENDED_HI   8'h15
`define PAV_ADDR_VBID_WSS_LO   8'h16
`define PAV_ADDR_VBID_WSS_HI   8'h17

`define PAV_RESET_CONTRAST     8'h80
`define PAV_RESET_BRIGHTNESS   8'h00
`define PAV_RESET_SATURATION   8'h80
`define PAV_RESET_HUE          8'h00
`define PAV_RESET_YC_DELAY     3'h0

`define PAV_REQ_CAPTION_BIT    0
`define PAV_REQ_EXTENDED_BIT   1
`define PAV_REQ_VBID_WSS_BIT   2
`define PAV_STATUS_FLAG_LSB    5

`define PAV_GAIN_SHIFT         7
`define PAV_HUE_MULT           5'h19
`define PAV_HUE_SHIFT          12
`define PAV_YC_DELAY_Y3        3'h5
`define PAV_YC_DELAY_Y1A       3'h6
`define PAV_YC_DELAY_Y1B       3'h7
`define PAV_YC_ADV_C2A         3'h1
`define PAV_YC_ADV_C2B         3'h2

`endif

// ---- src/pav_pkg.sv ----
// Types shared by the picture adjust register bank.
// Assumes nothing of its surroundings.
`default_nettype none

package pav_pkg;
	typedef enum logic {PAV_IDLE, PAV_ARMED} pav_decode_state_type;
	typedef logic [7:0]  pav_byte_type;
	typedef logic [15:0] pav_word_type;
endpackage : pav_pkg

`default_nettype wire

// ---- bench/pav_slicer_model.sv ----
// Stand-in for the blanking-data slicer that feeds the register bank.
// Assumes the bench raises fire for one cycle for each decode result it wants delivered.
`timescale 1ns/10ps
`default_nettype none

module pav_slicer_model #(
	parameter logic [4:0] ENGINE_STATUS = 5'h15
) (
	// Clock and reset.
	input  wire logic        clock,
	input  wire logic        reset_n,
	// Bench command.
	input  wire logic [2:0]  fire,
	input  wire logic [15:0] word,
	// Slicer outputs.
	output var  logic [2:0]  decode_done,
	output var  logic [15:0] caption_word,
	output var  logic [15:0] extended_word,
	output var  logic [15:0] vbid_wss_word,
	output var  logic [4:0]  engine_status
);
	assign engine_status = ENGINE_STATUS;

	// Words are valid only with their done bit; otherwise they toggle every cycle.
	always_ff @(posedge clock or negedge reset_n) begin
		if (!reset_n) begin
			decode_done   <= 3'h0;
			caption_word  <= 16'h0000;
			extended_word <= 16'h0000;
			vbid_wss_word <= 16'h0000;
		end else begin
			decode_done   <= fire;
			caption_word  <= fire[0] ? word : ~caption_word;
			extended_word <= fire[1] ? word : ~extended_word;
			vbid_wss_word <= fire[2] ? word : ~vbid_wss_word;
		end
	end
endmodule : pav_slicer_model

`default_nettype wire

// ---- bench/picture_adjust_vbi_request_regs_test.sv ----
// Self-checking bench of the picture adjust register bank.
// Assumes pav_regs_top and the slicer model, all on one 40 MHz clock.
`timescale 1ns/10ps
`default_nettype none

module picture_adjust_vbi_request_regs_test;
	logic              clock, reset_n, reg_write_strobe, sample_valid, sample_valid_out;
	logic [7:0]        reg_address, reg_write_data, reg_read_data, luma_in, luma_out;
	logic signed [7:0] cb_in, cr_in, cb_out, cr_out;
	logic [2:0]        decode_done, decode_ready, fire;
	logic [15:0]       caption_word, extended_word, vbid_wss_word, word;
	logic [4:0]        engine_status;
	logic [7:0]        ys[1:10], cs[1:10], rs[1:10];
	logic              vs[1:10];
	int                failures, checks, ly, cy, vy;
	int                ylat[8] = '{3, 3, 3, 3, 3, 6, 4, 4};
	int                clat[8] = '{3, 5, 5, 3, 3, 3, 3, 3};

	pav_regs_top u_dut (.clock(clock), .reset_n(reset_n), .reg_address(reg_address),
		.reg_write_strobe(reg_write_strobe), .reg_write_data(reg_write_data),
		.reg_read_data(reg_read_data), .sample_valid(sample_valid), .luma_in(luma_in),
		.cb_in(cb_in), .cr_in(cr_in), .sample_valid_out(sample_valid_out), .luma_out(luma_out),
		.cb_out(cb_out), .cr_out(cr_out), .decode_done(decode_done), .caption_word(caption_word),
		.extended_word(extended_word), .vbid_wss_word(vbid_wss_word),
		.engine_status(engine_status), .decode_ready(decode_ready));

	pav_slicer_model u_slicer (.clock(clock), .reset_n(reset_n), .fire(fire), .word(word),
		.decode_done(decode_done), .caption_word(caption_word), .extended_word(extended_word),
		.vbid_wss_word(vbid_wss_word), .engine_status(engine_status));

	initial begin
		clock = 1'b0;
		forever #12.5 clock = ~clock;
	end

	// ----------------------------------------
	// Access and comparison tasks
	// ----------------------------------------
	task check(input logic [15:0] seen, input logic [15:0] exp);
		checks++;
		if (seen !== exp) begin
			failures++;
			$display("MISMATCH time=%0t seen=%h expected=%h", $time, seen, exp);
		end
	endtask : check

	task wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock);
		reg_address <= a;
		reg_write_data <= d;
		reg_write_strobe <= 1'b1;
		@(posedge clock);
		reg_write_strobe <= 1'b0;
		#1;
	endtask : wr

	task rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clock);
		reg_address <= a;
		@(posedge clock);
		#1;
		check({8'h00, reg_read_data}, {8'h00, exp});
	endtask : rd

	task slice(input logic [2:0] f, input logic [15:0] w);
		@(posedge clock);
		fire <= f;
		word <= w;
		@(posedge clock);
		fire <= 3'h0;
	endtask : slice

	// Sends one sample and records ten output cycles; index n is the latency in cycles.
	task send(input logic [7:0] y, input logic [7:0] c);
		@(posedge clock);
		sample_valid <= 1'b1;
		luma_in <= y;
		cb_in <= c;
		for (int n = 1; n <= 10; n++) begin
			@(posedge clock);
			sample_valid <= 1'b0;
			luma_in <= 8'h00;
			cb_in <= 8'sh00;
			#1;
			vs[n] = sample_valid_out;
			ys[n] = luma_out;
			cs[n] = cb_out;
			rs[n] = cr_out;
		end
	endtask : send

	task print_verdict;
		$display("checks=%0d failures=%0d", checks, failures);
		if (failures == 0 && checks > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : print_verdict

	initial begin
		repeat (20000) @(posedge clock);
		failures++;
		print_verdict;
	end

	// ----------------------------------------
	// Test sequence
	// ----------------------------------------
	initial begin
		reset_n = 1'b0;
		reg_address = 8'h00;
		reg_write_data = 8'h00;
		reg_write_strobe = 1'b0;
		sample_valid = 1'b0;
		luma_in = 8'h00;
		cb_in = 8'sh00;
		cr_in = 8'sh00;
		fire = 3'h0;
		word = 16'h0000;
		failures = 0;
		checks = 0;
		repeat (20) @(posedge clock);
		reset_n <= 1'b1;
		rd(8'h06, 8'h80);
		rd(8'h07, 8'h00);
		rd(8'h08, 8'h80);
		rd(8'h09, 8'h00);
		rd(8'h0b, 8'h00);
		rd(8'h10, 8'h15);
		rd(8'h20, 8'h00);
		check({13'h0, decode_ready}, 16'h0000);
		for (int i = 6; i <= 9; i++) begin
			wr(8'(i), 8'h5a ^ 8'(i));
			rd(8'(i), 8'h5a ^ 8'(i));
			wr(8'(i), i % 2 == 0 ? 8'h80 : 8'h00);
		end
		wr(8'h0a, 8'h07);
		check({13'h0, decode_ready}, 16'h0007);
		slice(3'h1, 16'hc3a5);
		rd(8'h10, 8'h35);
		check({13'h0, decode_ready}, 16'h0006);
		rd(8'h12, 8'ha5);
		rd(8'h13, 8'hc3);
		slice(3'h6, 16'h5a0f);
		rd(8'h10, 8'hf5);
		rd(8'h14, 8'h0f);
		rd(8'h17, 8'h5a);
		wr(8'h0a, 8'hf8);
		rd(8'h10, 8'hf5);
		rd(8'h0a, 8'h00);
		check({13'h0, decode_ready}, 16'h0000);
		wr(8'h0a, 8'h02);
		rd(8'h10, 8'h15);
		slice(3'h1, 16'h1111);
		rd(8'h10, 8'h15);
		rd(8'h12, 8'ha5);
		check({13'h0, decode_ready}, 16'h0002);
		send(8'd200, 8'd40);
		check({8'h00, ys[3]}, 16'h00c8);
		check({8'h00, cs[3]}, 16'h0028);
		wr(8'h06, 8'h40);
		send(8'd200, 8'd40);
		check({8'h00, ys[3]}, 16'h0064);
		wr(8'h06, 8'h80);
		wr(8'h07, 8'hf6);
		send(8'd200, 8'd40);
		check({8'h00, ys[3]}, 16'h00be);
		wr(8'h07, 8'h00);
		wr(8'h08, 8'h00);
		send(8'd200, 8'd40);
		check({8'h00, cs[3]}, 16'h0000);
		wr(8'h08, 8'hff);
		send(8'd200, 8'd40);
		check({8'h00, cs[3]}, 16'h004f);
		wr(8'h08, 8'h80);
		wr(8'h09, 8'h40);
		send(8'd200, 8'd40);
		check({8'h00, rs[3]}, 16'h000f);
		wr(8'h09, 8'h00);
		for (int k = 0; k < 8; k++) begin
			wr(8'h0b, 8'hf8 | 8'(k));
			rd(8'h0b, 8'(k));
			send(8'd200, 8'd40);
			ly = 0;
			cy = 0;
			vy = 0;
			for (int n = 10; n >= 1; n--) begin
				if (ys[n] === 8'd200) ly = n;
				if (cs[n] === 8'd40) cy = n;
				if (vs[n] === 1'b1) vy = n;
			end
			check(16'(ly), 16'(ylat[k]));
			check(16'(cy), 16'(clat[k]));
			check(16'(vy), 16'((ylat[k] > clat[k]) ? ylat[k] : clat[k]));
		end
		print_verdict;
	end
endmodule : picture_adjust_vbi_request_regs_test

`default_nettype wire
